// *** hw/svr_pkg.sv ***
// Package of constants and types for the single vehicle release signal controller.
package svr_pkg;
  // System clock rate and derived one-second tick.
  localparam int unsigned SVR_CLK_HZ = 50_000_000;
  localparam int unsigned SVR_TICK_CYCLES = SVR_CLK_HZ;
  // Timing figures in seconds.
  localparam logic [7:0] SVR_MIN_RED_FLOOR_S = 8'h02;
  localparam logic [7:0] SVR_EXIT_FLASH_FLOOR_S = 8'h05;
  localparam logic [7:0] SVR_MAX_RATE_GREEN_S = 8'h02;
  localparam logic [7:0] SVR_DEF_MIN_RED_S = 8'h04;
  localparam logic [7:0] SVR_DEF_MIN_GREEN_S = 8'h02;
  localparam logic [7:0] SVR_QUEUE_CUT_MAX_S = 8'h02;
  // Flash half period in cycles (0.5 s on, 0.5 s off).
  localparam int unsigned SVR_FLASH_HALF_CYCLES = SVR_CLK_HZ / 2;
  // Operating modes.
  typedef enum logic [1:0] {
    SVR_MODE_METER,
    SVR_MODE_BOOTH,
    SVR_MODE_CONT_GREEN
  } svr_mode_t;
  // Sequencer states.
  typedef enum logic [2:0] {
    SVR_ST_RED,
    SVR_ST_GREEN,
    SVR_ST_CONT_GREEN,
    SVR_ST_EXIT_FLASH,
    SVR_ST_FAULT_FLASH,
    SVR_ST_DARK
  } svr_state_t;
endpackage : svr_pkg

// *** hw/svr_tick_if.sv ***
// Interface carrying the tick and flash phase between timebase and sequencer.
`timescale 1ns/1ns
interface svr_tick_if;
  logic sec_tick;
  logic flash_on;
  modport src (output sec_tick, output flash_on);
  modport dst (input sec_tick, input flash_on);
endinterface : svr_tick_if

// *** hw/svr_timebase.sv ***
// Timebase producing a one-second tick and the flashing lamp phase.
`timescale 1ns/1ns
module svr_timebase
  import svr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SVR_TICK_CYCLES,
  parameter int unsigned FLASH_HALF = SVR_FLASH_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  svr_tick_if.src tk
);
  logic [31:0] sec_cnt;
  logic [31:0] next_sec_cnt;
  logic [31:0] fl_cnt;
  logic [31:0] next_fl_cnt;
  logic tick;
  logic next_tick;
  logic phase;
  logic next_phase;

  // Elaboration check: a tick needs at least two cycles and the flash at least one.
  if (TICK_CYCLES < 2 || FLASH_HALF < 1) begin : g_bad_counts
    $error("svr_timebase: counts too small");
  end

  // Free running dividers; the tick is a one-cycle pulse once per second.
  always_comb begin
    next_tick = 1'b0;
    next_sec_cnt = sec_cnt + 32'h0000_0001;
    if (sec_cnt == TICK_CYCLES - 1) begin
      next_sec_cnt = 32'h0000_0000;
      next_tick = 1'b1;
    end
    next_fl_cnt = fl_cnt + 32'h0000_0001;
    next_phase = phase;
    if (fl_cnt == FLASH_HALF - 1) begin
      next_fl_cnt = 32'h0000_0000;
      next_phase = ~phase;
    end
  end

  // Registers of the timebase.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sec_cnt <= 32'h0000_0000;
      fl_cnt <= 32'h0000_0000;
      tick <= 1'b0;
      phase <= 1'b1;
    end else begin
      sec_cnt <= next_sec_cnt;
      fl_cnt <= next_fl_cnt;
      tick <= next_tick;
      phase <= next_phase;
    end
  end

  assign tk.sec_tick = tick;
  assign tk.flash_on = phase;
endmodule : svr_timebase

// *** hw/svr_release_ctrl.sv ***
// Sequencer for a two-aspect single vehicle release signal face.
// Overview of operation
// - Only red and green lamps are driven; no amber interval exists anywhere.
// - Continuous-green mode keeps green lit for every approaching vehicle.
// - Leaving continuous green first shows flashing red for at least five second ticks (over four seconds).
// - Both lamps steadily dark only while the maintenance or officer override is asserted.
// - An asserted fault shows flashing red meaning out of order.
// - Metering rests in steady red and gives short green per stopped vehicle.
// - Booth mode grants green only with a vehicle present at the stop.
// - Booth green ends from the lane detector, not from a timer.
// - Metering green starts on check-in once minimum red has elapsed.
// - Check-out ends green at once, or when minimum green ends.
// - Minimum green is timed from the check-out rising edge.
// - Green length follows detectors until the vehicle clears sight line.
// - A present gap detector must confirm a mainline gap before metering green.
// - A long queue shortens minimum red, bounded, until the queue clears.
// - Effective minimum red is never below two seconds.
// - Top rate is two green, two red seconds; slower means longer red.
// - Two seconds green and four red give about six hundred per hour.
`timescale 1ns/1ns
module svr_release_ctrl
  import svr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SVR_TICK_CYCLES,
  parameter int unsigned FLASH_HALF = SVR_FLASH_HALF_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire svr_mode_t mode,
  input wire logic [7:0] min_red_s,
  input wire logic [7:0] min_green_s,
  input wire logic [7:0] exit_flash_s,
  input wire logic [7:0] queue_cut_s,
  input wire logic check_in,
  input wire logic check_out,
  input wire logic gap_present,
  input wire logic gap_ok,
  input wire logic queue_long,
  input wire logic booth_present,
  input wire logic booth_clear,
  input wire logic green_req,
  input wire logic fault,
  input wire logic dark_override,
  output logic red_lamp,
  output logic green_lamp,
  output logic out_of_order,
  output logic pending_call,
  output svr_state_t state_out
);
  svr_tick_if tk();

  svr_timebase #(
    .TICK_CYCLES(TICK_CYCLES),
    .FLASH_HALF(FLASH_HALF)
  ) u_timebase (
    .mclk(mclk),
    .rst_b(rst_b),
    .tk(tk)
  );

  // Two-flop synchronisers for every pin-level detector and request input; dark_override is used unsynchronised.
  localparam int unsigned NSYNC = 9;
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] pins;
  assign pins = {check_in, check_out, gap_present, gap_ok, queue_long, booth_present, booth_clear, green_req, fault};
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
    end
  end
  logic s_in, s_out, s_gap_pres, s_gap_ok, s_queue, s_present, s_clear, s_req, s_fault;
  assign {s_in, s_out, s_gap_pres, s_gap_ok, s_queue, s_present, s_clear, s_req, s_fault} = sync_b;

  // Settings are clamped so minimum red and the exit flash never undercut their floors.
  logic [7:0] cut;
  logic [7:0] red_raw;
  logic [7:0] eff_min_red;
  logic [7:0] eff_flash;
  always_comb begin
    cut = (queue_cut_s > SVR_QUEUE_CUT_MAX_S) ? SVR_QUEUE_CUT_MAX_S : queue_cut_s;
    red_raw = (min_red_s < SVR_MIN_RED_FLOOR_S) ? SVR_MIN_RED_FLOOR_S : min_red_s;
    if (s_queue && red_raw > cut) begin
      red_raw = red_raw - cut;
    end
    // Floor applied after the queue cut, so rate increases cannot go below it.
    eff_min_red = (red_raw < SVR_MIN_RED_FLOOR_S) ? SVR_MIN_RED_FLOOR_S : red_raw;
    eff_flash = (exit_flash_s < SVR_EXIT_FLASH_FLOOR_S) ? SVR_EXIT_FLASH_FLOOR_S : exit_flash_s;
  end

  // Sequencer state, interval timer, check-out edge tracking and pending call.
  svr_state_t state;
  svr_state_t next_state;
  logic [7:0] timer;
  logic [7:0] next_timer;
  logic red_done;
  logic next_red_done;
  logic out_seen;
  logic next_out_seen;
  logic out_prev;
  logic pend;
  logic next_pend;
  logic clash;
  logic clash_flag;
  logic next_clash_flag;
  logic out_rise;
  logic gap_clear;

  assign out_rise = s_out && !out_prev;
  // Without a gap detector the gap check is simply satisfied.
  assign gap_clear = !s_gap_pres || s_gap_ok;

  always_comb begin
    next_state = state;
    next_timer = timer;
    next_red_done = red_done;
    next_out_seen = out_seen;
    next_pend = pend;
    next_clash_flag = clash_flag | clash;
    // Check-in is latched as a call; it does not touch the red timer.
    if (s_in && mode == SVR_MODE_METER) begin
      next_pend = 1'b1;
    end
    if (tk.sec_tick && timer != 8'h00) begin
      next_timer = timer - 8'h01;
    end
    if (dark_override) begin
      next_state = SVR_ST_DARK;
    end else if (s_fault || clash_flag) begin
      next_state = SVR_ST_FAULT_FLASH;
    end else begin
      case (state)
        SVR_ST_RED: begin
          if (tk.sec_tick && timer <= 8'h01) begin
            next_red_done = 1'b1;
          end
          if (mode == SVR_MODE_CONT_GREEN) begin
            next_state = SVR_ST_CONT_GREEN;
          end else if (mode == SVR_MODE_BOOTH) begin
            next_pend = 1'b0;
            if (s_req && s_present) begin
              next_state = SVR_ST_GREEN;
            end
          end else if (red_done && pend && s_in && gap_clear) begin
            next_state = SVR_ST_GREEN;
            next_pend = 1'b0;
            next_out_seen = 1'b0;
            next_timer = 8'h00;
          end
        end
        SVR_ST_GREEN: begin
          if (mode == SVR_MODE_BOOTH) begin
            // Detector clears the vehicle; no timer governs booth green.
            if (s_clear || !s_present) begin
              next_state = SVR_ST_RED;
            end
          end else if (mode == SVR_MODE_CONT_GREEN) begin
            next_state = SVR_ST_CONT_GREEN;
          end else begin
            if (out_rise && !out_seen) begin
              next_out_seen = 1'b1;
              next_timer = min_green_s;
              if (min_green_s == 8'h00) begin
                next_state = SVR_ST_RED;
              end
            end else if (out_seen && (timer == 8'h00 || (tk.sec_tick && timer == 8'h01))) begin
              // Green ends once minimum green, timed from the check-out rising edge, has run out.
              next_state = SVR_ST_RED;
            end
          end
          if (next_state == SVR_ST_RED) begin
            next_timer = eff_min_red;
            next_red_done = 1'b0;
          end
        end
        SVR_ST_CONT_GREEN: begin
          if (mode != SVR_MODE_CONT_GREEN) begin
            next_state = SVR_ST_EXIT_FLASH;
            next_timer = eff_flash;
          end
        end
        SVR_ST_EXIT_FLASH: begin
          if (tk.sec_tick && timer <= 8'h01) begin
            next_state = SVR_ST_RED;
            next_timer = eff_min_red;
            next_red_done = 1'b0;
          end
        end
        SVR_ST_FAULT_FLASH, SVR_ST_DARK: begin
          // Recovery always passes through red; only metering mode then waits out the full minimum red.
          next_state = SVR_ST_RED;
          next_timer = eff_min_red;
          next_red_done = 1'b0;
          next_clash_flag = 1'b0;
        end
        default: begin
          next_state = SVR_ST_RED;
        end
      endcase
    end
  end

  // Reset enters steady red with all timers cleared.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= SVR_ST_RED;
      timer <= 8'h00;
      red_done <= 1'b0;
      out_seen <= 1'b0;
      out_prev <= 1'b0;
      pend <= 1'b0;
      clash_flag <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      red_done <= next_red_done;
      out_seen <= next_out_seen;
      out_prev <= s_out;
      pend <= next_pend;
      clash_flag <= next_clash_flag;
    end
  end

  // Lamp decode; only two aspects exist, so no amber path is possible.
  logic next_red;
  logic next_green;
  always_comb begin
    next_red = 1'b1;
    next_green = 1'b0;
    case (state)
      SVR_ST_GREEN, SVR_ST_CONT_GREEN: begin
        next_red = 1'b0;
        next_green = 1'b1;
      end
      SVR_ST_EXIT_FLASH, SVR_ST_FAULT_FLASH: begin
        next_red = tk.flash_on;
      end
      SVR_ST_DARK: begin
        next_red = 1'b0;
      end
      default: begin
        next_red = 1'b1;
      end
    endcase
  end
  // A decode clash is caught here, latched in clash_flag next cycle, and drives the fault flash the cycle after.
  assign clash = next_red && next_green;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      red_lamp <= 1'b1;
      green_lamp <= 1'b0;
      out_of_order <= 1'b0;
      pending_call <= 1'b0;
      state_out <= SVR_ST_RED;
    end else begin
      red_lamp <= next_red;
      green_lamp <= next_green && !next_red;
      out_of_order <= (state == SVR_ST_FAULT_FLASH);
      pending_call <= pend;
      state_out <= state;
    end
  end
endmodule : svr_release_ctrl

// *** test/svr_release_monitor.sv ***
// Checker bound to the signal controller, watching lamp, state and detector ports.
`timescale 1ns/1ns
module svr_release_monitor
  import svr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SVR_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire svr_mode_t mode,
  input wire logic check_in,
  input wire logic booth_present,
  input wire logic fault,
  input wire logic dark_override,
  input wire logic red_lamp,
  input wire logic green_lamp,
  input wire svr_state_t state_out
);
  logic [9:0] red_cnt;
  logic [9:0] flash_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Run lengths of red and exit flash live in counters, since they are far too long for a repetition.
  always_ff @(posedge mclk) begin
    if (!rst_b || state_out != SVR_ST_RED) red_cnt <= 10'h000;
    else if (red_cnt != 10'h3ff) red_cnt <= red_cnt + 10'h001;
    if (!rst_b || state_out != SVR_ST_EXIT_FLASH) flash_cnt <= 10'h000;
    else if (flash_cnt != 10'h3ff) flash_cnt <= flash_cnt + 10'h001;
  end

  a_lamps_exclusive: assert property (!(red_lamp && green_lamp))
    else $error("red and green lit together");
  a_green_source: assert property (green_lamp |-> state_out inside {SVR_ST_GREEN, SVR_ST_CONT_GREEN})
    else $error("green lit outside a green state");
  a_red_rest: assert property (state_out == SVR_ST_RED |-> red_lamp && !green_lamp)
    else $error("red state without steady red");
  a_reset_red: assert property (disable iff (1'b0) !rst_b |=> red_lamp && !green_lamp && state_out == SVR_ST_RED)
    else $error("reset did not give steady red");
  a_dark_cause: assert property (state_out == SVR_ST_DARK |->
    !red_lamp && !green_lamp && $past(dark_override, 2))
    else $error("dark face without override");
  a_fault_shows: assert property ((fault && !dark_override) [*8] |-> state_out == SVR_ST_FAULT_FLASH)
    else $error("fault not shown as flashing red");
  a_booth_presence: assert property ((mode == SVR_MODE_BOOTH && !booth_present) [*6] |-> state_out != SVR_ST_GREEN)
    else $error("booth green with nobody at the stop");
  a_call_needed: assert property ((mode == SVR_MODE_METER && !check_in) [*6] |->
    !(state_out == SVR_ST_GREEN && $past(state_out) == SVR_ST_RED))
    else $error("metering green without a waiting vehicle");
  a_min_red: assert property (mode == SVR_MODE_METER && state_out == SVR_ST_GREEN && $past(state_out) == SVR_ST_RED
    |-> $past(red_cnt) >= TICK_CYCLES - 2)
    else $error("red shorter than its floor");
  a_exit_flash: assert property (state_out == SVR_ST_RED && $past(state_out) == SVR_ST_EXIT_FLASH
    |-> $past(flash_cnt) >= 4 * TICK_CYCLES - 2)
    else $error("exit flash too short");

  // Main scenarios that the bench is expected to reach.
  c_meter_green: cover property (mode == SVR_MODE_METER && state_out == SVR_ST_GREEN);
  c_exit_flash: cover property ($fell(state_out == SVR_ST_EXIT_FLASH));
  c_fault: cover property (state_out == SVR_ST_FAULT_FLASH);
  c_dark: cover property (state_out == SVR_ST_DARK);
endmodule : svr_release_monitor

// *** test/svr_lane_model.sv ***
// Model of one metered lane: a vehicle on the check-in loop that leaves over the check-out loop.
`timescale 1ns/1ns
module svr_lane_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic arrive,
  input wire logic green_lamp,
  output logic check_in,
  output logic check_out
);
  logic [6:0] cnt;

  // The vehicle waits on check-in until green, then reaches check-out four cycles after green_lamp rises.
  // The count rearms only once red is back, so a long green never yields a second check-out pulse.
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      check_in <= 1'h0;
      check_out <= 1'h0;
      cnt <= 7'h00;
    end else begin
      if (arrive) check_in <= 1'h1;
      else if (green_lamp) check_in <= 1'h0;
      if (!green_lamp && cnt > 7'h08) cnt <= 7'h00;
      else if (green_lamp && cnt == 7'h00) cnt <= 7'h01;
      else if (cnt != 7'h00 && cnt != 7'h7f) cnt <= cnt + 7'h01;
      check_out <= cnt >= 7'h03 && cnt < 7'h09;
    end
  end
endmodule : svr_lane_model

// *** test/tb.sv ***
// Self-checking bench for the signal controller with a short tick.
`timescale 1ns/1ns
module tb;
  import svr_pkg::*;
  localparam int unsigned TICK = 20;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  svr_mode_t mode = SVR_MODE_METER;
  logic [7:0] min_red_s = 8'h04;
  logic [7:0] min_green_s = 8'h02;
  logic [7:0] exit_flash_s = 8'h05;
  logic [7:0] queue_cut_s = 8'h02;
  logic gap_present = 1'h0, gap_ok = 1'h0, queue_long = 1'h0, booth_present = 1'h0, booth_clear = 1'h0;
  logic green_req = 1'h0, fault = 1'h0, dark_override = 1'h0, arrive = 1'h0;
  logic check_in, check_out, red_lamp, green_lamp, out_of_order, pending_call;
  svr_state_t state_out;
  int num_errors = 0;
  int checks_done = 0;
  int n;

  // Free-running 50 MHz clock.
  always #10 mclk = ~mclk;

  svr_release_ctrl #(.TICK_CYCLES(TICK), .FLASH_HALF(4)) i_dut (.mclk(mclk), .rst_b(rst_b), .mode(mode),
    .min_red_s(min_red_s), .min_green_s(min_green_s), .exit_flash_s(exit_flash_s), .queue_cut_s(queue_cut_s),
    .check_in(check_in), .check_out(check_out), .gap_present(gap_present), .gap_ok(gap_ok),
    .queue_long(queue_long), .booth_present(booth_present), .booth_clear(booth_clear), .green_req(green_req),
    .fault(fault), .dark_override(dark_override), .red_lamp(red_lamp), .green_lamp(green_lamp),
    .out_of_order(out_of_order), .pending_call(pending_call), .state_out(state_out));
  svr_lane_model i_lane (.mclk(mclk), .rst_b(rst_b), .arrive(arrive), .green_lamp(green_lamp),
    .check_in(check_in), .check_out(check_out));

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // Waits for a state, sampling just after each edge; n equals lim when it never came.
  task automatic wait_st(input svr_state_t s, input int lim, output int cnt);
    cnt = 0;
    while (state_out !== s && cnt < lim) begin
      @(posedge mclk);
      #1;
      cnt++;
    end
  endtask : wait_st

  task automatic call_car;
    @(posedge mclk);
    arrive <= 1'h1;
    @(posedge mclk);
    arrive <= 1'h0;
  endtask : call_car

  // One vehicle called at the start of red; the red and green lengths are both measured.
  task automatic car(input int lo, input int hi);
    int m;
    wait_st(SVR_ST_RED, 100, m);
    call_car();
    repeat (4) @(posedge mclk);
    #1;
    chk(pending_call === 1'h1, "call not held during red");
    wait_st(SVR_ST_GREEN, 300, m);
    chk(m + 6 >= lo && m + 6 <= hi, "red interval out of range");
    wait_st(SVR_ST_RED, 100, m);
    chk(m >= TICK && m <= 3 * TICK, "green interval out of range");
  endtask : car

  // A new setting is taken up on a first vehicle, then timed on a second one.
  task automatic leg(input logic [7:0] r, input logic q, input int lo, input int hi);
    @(posedge mclk);
    min_red_s <= r;
    queue_long <= q;
    car(0, 400);
    car(lo, hi);
  endtask : leg

  // Watchdog reckoned at several times the expected run length.
  initial begin
    #400000;
    num_errors++;
    $display("mismatch at %0t: run timed out", $time);
    test_done();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    #1;
    chk(red_lamp === 1'h1 && green_lamp === 1'h0 && state_out === SVR_ST_RED && pending_call === 1'h0, "reset");
    leg(8'h04, 1'h0, 3 * TICK - 2, 4 * TICK + 10);
    leg(8'h01, 1'h0, TICK - 2, 2 * TICK + 10);
    leg(8'h04, 1'h1, TICK - 2, 2 * TICK + 10);
    leg(8'h04, 1'h0, 3 * TICK - 2, 4 * TICK + 10);
    @(posedge mclk);
    gap_present <= 1'h1;
    call_car();
    wait_st(SVR_ST_GREEN, 6 * TICK, n);
    chk(n == 6 * TICK, "green given without a mainline gap");
    @(posedge mclk);
    gap_ok <= 1'h1;
    wait_st(SVR_ST_GREEN, 10, n);
    chk(n < 10, "green held after gap confirmed");
    wait_st(SVR_ST_RED, 100, n);
    @(posedge mclk);
    gap_present <= 1'h0;
    mode <= SVR_MODE_BOOTH;
    green_req <= 1'h1;
    wait_st(SVR_ST_GREEN, 40, n);
    chk(n == 40, "booth green with no vehicle present");
    @(posedge mclk);
    booth_present <= 1'h1;
    wait_st(SVR_ST_GREEN, 120, n);
    chk(n < 120, "booth green not granted");
    repeat (3 * TICK) @(posedge mclk);
    #1;
    chk(state_out === SVR_ST_GREEN, "booth green ended by a timer");
    @(posedge mclk);
    booth_clear <= 1'h1;
    wait_st(SVR_ST_RED, 20, n);
    chk(n < 20, "booth red not returned on clear");
    @(posedge mclk);
    booth_clear <= 1'h0;
    booth_present <= 1'h0;
    green_req <= 1'h0;
    mode <= SVR_MODE_CONT_GREEN;
    wait_st(SVR_ST_CONT_GREEN, 120, n);
    repeat (10 * TICK) @(posedge mclk);
    #1;
    chk(green_lamp === 1'h1 && red_lamp === 1'h0, "continuous green not held");
    @(posedge mclk);
    mode <= SVR_MODE_METER;
    wait_st(SVR_ST_EXIT_FLASH, 10, n);
    chk(n < 10, "no flashing red on leaving continuous green");
    wait_st(SVR_ST_RED, 200, n);
    chk(n >= 4 * TICK - 2 && n <= 5 * TICK + 4, "exit flash length");
    @(posedge mclk);
    fault <= 1'h1;
    wait_st(SVR_ST_FAULT_FLASH, 10, n);
    @(posedge mclk);
    #1;
    chk(n < 10 && out_of_order === 1'h1, "fault not shown");
    @(posedge mclk);
    fault <= 1'h0;
    wait_st(SVR_ST_RED, 10, n);
    chk(n < 10, "no red after fault");
    @(posedge mclk);
    dark_override <= 1'h1;
    wait_st(SVR_ST_DARK, 10, n);
    @(posedge mclk);
    #1;
    chk(n < 10 && red_lamp === 1'h0 && green_lamp === 1'h0, "override did not darken");
    @(posedge mclk);
    dark_override <= 1'h0;
    wait_st(SVR_ST_RED, 10, n);
    chk(n < 10, "no red after override");
    test_done();
  end
endmodule : tb

bind svr_release_ctrl svr_release_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_mon (.mclk(mclk), .rst_b(rst_b),
  .mode(mode), .check_in(check_in), .booth_present(booth_present), .fault(fault),
  .dark_override(dark_override), .red_lamp(red_lamp), .green_lamp(green_lamp), .state_out(state_out));
